// [rtl/uart_pin_suspend_config.sv]
// apb register bank and pin steering for data-pin and suspend pin configuration
`timescale 1ns/1ps

// Functional notes
// - data byte bit7 set turns rx pull-up off
// - bit6 enables rx pull-down unless pull-up on
// - bit5 lets rx wake, needs global wake enable
// - bit0 selects tx push-pull or open-drain
// - suspend settings never touch rx and tx
// - master suspend bit gates all forced pin settings
// - master bit is bit7 of a driver byte
// - high level byte maps io9,8,7,4,5,6
// - low level byte maps io2,3,0,1
// - driver bit: 0 push-pull, 1 open-drain
// - high driver byte uses high level mapping
// - low driver byte maps io2,3,0,1
// - two channels, own zeroed bytes at own offsets
module uart_pin_suspend_config #(
   parameter int ADDR_WIDTH = 12,   // apb byte address width
   parameter int CHANNELS   = 2,    // uart channels
   parameter int IO_COUNT   = 10    // modem/gpio pins per channel
) (
   // clock and reset
   input  wire logic                          i_clock,
   input  wire logic                          i_rstn,
   // apb slave
   input  wire logic                          i_psel,
   input  wire logic                          i_penable,
   input  wire logic                          i_pwrite,
   input  wire logic [ADDR_WIDTH-1:0]         i_paddr,
   input  wire logic [31:0]                   i_pwdata,
   output logic      [31:0]                   o_prdata,
   output logic                               o_pready,
   output logic                               o_pslverr,
   // usb state
   input  wire logic                          i_usb_suspend,
   input  wire logic                          i_global_wake_en,
   // data pins
   input  wire logic [CHANNELS-1:0]           i_rx_pin,
   input  wire logic [CHANNELS-1:0]           i_tx_data,
   output logic      [CHANNELS-1:0]           o_tx_out,
   output logic      [CHANNELS-1:0]           o_tx_oe,
   output logic      [CHANNELS-1:0]           o_rx_pullup_en,
   output logic      [CHANNELS-1:0]           o_rx_pulldown_en,
   output logic      [CHANNELS-1:0]           o_wake_request,
   // modem/gpio pins, normal function in, pad drive out
   input  wire logic [CHANNELS-1:0][IO_COUNT-1:0] i_gpio_out,
   input  wire logic [CHANNELS-1:0][IO_COUNT-1:0] i_gpio_oe,
   output logic      [CHANNELS-1:0][IO_COUNT-1:0] o_gpio_out,
   output logic      [CHANNELS-1:0][IO_COUNT-1:0] o_gpio_oe
);
   import pin_suspend_pkg::*;

   // register bank, one row per channel
   logic [7:0]            cfg [CHANNELS][SLOT_COUNT];
   // usb suspend synchroniser and its settled copy
   logic                  susp_meta;
   logic                  susp_sync;
   // rx pin synchroniser plus a history stage for edge detection
   logic [CHANNELS-1:0]   rx_meta;
   logic [CHANNELS-1:0]   rx_sync;
   logic [CHANNELS-1:0]   rx_prev;
   // per-channel suspend override active
   logic [CHANNELS-1:0]   forced;
   // suspend level and driver bits spread into io order, per channel
   logic [CHANNELS-1:0][9:0] lvl_map;
   logic [CHANNELS-1:0][9:0] drv_map;
   // decoded access
   logic [4:0]            dec;
   logic                  acc_start;
   logic                  acc_done;

   // address to {hit, channel, slot}; word aligned only
   function automatic logic [4:0] decode(input logic [ADDR_WIDTH-1:0] addr);
      logic [9:0] idx;
      idx = 10'(addr >> 2);
      decode = 5'h00;
      if (addr[1:0] == 2'h0) begin
         if (idx >= CH0_DATA_PIN_CONFIG_IDX && idx <= CH0_SUSPEND_DRIVER_LOW_IDX) begin
            decode = {1'b1, 1'b0, 3'(idx - CH0_DATA_PIN_CONFIG_IDX)};
         end else if (idx >= CH1_DATA_PIN_CONFIG_IDX && idx <= CH1_SUSPEND_DRIVER_LOW_IDX) begin
            decode = {1'b1, 1'b1, 3'(idx - CH1_DATA_PIN_CONFIG_IDX)};
         end
      end
   endfunction : decode

   // writable bits of a slot
   function automatic logic [7:0] slot_mask(input logic [2:0] slot);
      case (slot)
         SLOT_DATA_PIN:    slot_mask = MASK_DATA_PIN;
         SLOT_LEVEL_HIGH:  slot_mask = MASK_HIGH;
         SLOT_LEVEL_LOW:   slot_mask = MASK_LEVEL_LOW;
         SLOT_DRIVER_HIGH: slot_mask = MASK_HIGH;
         SLOT_DRIVER_LOW:  slot_mask = MASK_DRIVER_LOW;
         default:          slot_mask = 8'h00;
      endcase
   endfunction : slot_mask

   // spread a high/low byte pair onto pins io0..io9
   function automatic logic [9:0] pin_map(input logic [7:0] hi, input logic [7:0] lo);
      pin_map     = 10'h000;
      pin_map[9]  = hi[HI_IO9_BIT];
      pin_map[8]  = hi[HI_IO8_BIT];
      pin_map[7]  = hi[HI_IO7_BIT];
      pin_map[4]  = hi[HI_IO4_BIT];
      pin_map[5]  = hi[HI_IO5_BIT];
      pin_map[6]  = hi[HI_IO6_BIT];
      pin_map[2]  = lo[LO_IO2_BIT];
      pin_map[3]  = lo[LO_IO3_BIT];
      pin_map[0]  = lo[LO_IO0_BIT];
      pin_map[1]  = lo[LO_IO1_BIT];
   endfunction : pin_map

   assign dec       = decode(i_paddr);
   // one wait state: first access cycle raises pready, next edge completes
   assign acc_start = i_psel && i_penable && !o_pready;
   assign acc_done  = i_psel && i_penable && o_pready;

   // apb handshake and read data, both registered
   always_ff @(posedge i_clock or negedge i_rstn) begin
      if (!i_rstn) begin
         o_pready  <= 1'b0;
         o_pslverr <= 1'b0;
         o_prdata  <= 32'h0000_0000;
      end else begin
         o_pready  <= acc_start;
         o_pslverr <= acc_start && !dec[4];   // unmapped answers with an error
         if (acc_start && !i_pwrite && dec[4]) begin
            o_prdata <= {24'h00_0000, cfg[dec[3]][dec[2:0]]};
         end else begin
            o_prdata <= 32'h0000_0000;
         end
      end
   end

   // register writes at the completing edge; reserved bits are dropped so
   // a careless write of ones there cannot leak into pin control
   always_ff @(posedge i_clock or negedge i_rstn) begin
      if (!i_rstn) begin
         for (int c = 0; c < CHANNELS; c++) begin
            for (int s = 0; s < SLOT_COUNT; s++) begin
               cfg[c][s] <= CONFIG_RESET;
            end
         end
      end else if (acc_done && i_pwrite && dec[4]) begin
         cfg[dec[3]][dec[2:0]] <= i_pwdata[7:0] & slot_mask(dec[2:0]);
      end
   end

   // suspend comes from the usb core's own timing, so it is synchronised
   always_ff @(posedge i_clock or negedge i_rstn) begin
      if (!i_rstn) begin
         susp_meta <= 1'b0;
         susp_sync <= 1'b0;
      end else begin
         susp_meta <= i_usb_suspend;
         susp_sync <= susp_meta;
      end
   end

   // rx pin synchroniser; only the second stage feeds the edge detector
   always_ff @(posedge i_clock or negedge i_rstn) begin
      if (!i_rstn) begin
         rx_meta <= '1;
         rx_sync <= '1;
         rx_prev <= '1;
      end else begin
         rx_meta <= i_rx_pin;
         rx_sync <= rx_meta;
         rx_prev <= rx_sync;
      end
   end

   // override only while suspended and the master bit is set
   always_comb begin
      for (int c = 0; c < CHANNELS; c++) begin
         forced[c] = susp_sync && cfg[c][SLOT_DRIVER_LOW][USE_SUSPEND_BIT];
      end
   end

   // spread the suspend bytes once here; a bit-select of a function result
   // is not accepted everywhere, so the pad process reads plain vectors
   // instead of calling the map per pin
   always_comb begin
      for (int c = 0; c < CHANNELS; c++) begin
         lvl_map[c] = pin_map(cfg[c][SLOT_LEVEL_HIGH], cfg[c][SLOT_LEVEL_LOW]);
         drv_map[c] = pin_map(cfg[c][SLOT_DRIVER_HIGH], cfg[c][SLOT_DRIVER_LOW]);
      end
   end

   // data pins: steered only by the data-pin byte, never by suspend bytes
   always_ff @(posedge i_clock or negedge i_rstn) begin
      if (!i_rstn) begin
         o_rx_pullup_en   <= '0;
         o_rx_pulldown_en <= '0;
         o_tx_out         <= '0;
         o_tx_oe          <= '0;
      end else begin
         for (int c = 0; c < CHANNELS; c++) begin
            o_rx_pullup_en[c]   <= !cfg[c][SLOT_DATA_PIN][RX_PULLUP_OFF_BIT];
            // pull-down yields whenever the pull-up is on
            o_rx_pulldown_en[c] <= cfg[c][SLOT_DATA_PIN][RX_PULLDOWN_EN_BIT]
                                   && cfg[c][SLOT_DATA_PIN][RX_PULLUP_OFF_BIT];
            if (cfg[c][SLOT_DATA_PIN][TX_OPEN_DRAIN_BIT]) begin
               o_tx_out[c] <= 1'b0;            // open-drain: only ever pulls low
               o_tx_oe[c]  <= !i_tx_data[c];
            end else begin
               o_tx_out[c] <= i_tx_data[c];    // push-pull
               o_tx_oe[c]  <= 1'b1;
            end
         end
      end
   end

   // remote wakeup: any rx edge while suspended, if both enables are set
   always_ff @(posedge i_clock or negedge i_rstn) begin
      if (!i_rstn) begin
         o_wake_request <= '0;
      end else begin
         for (int c = 0; c < CHANNELS; c++) begin
            o_wake_request[c] <= susp_sync && i_global_wake_en
                                 && cfg[c][SLOT_DATA_PIN][RX_WAKE_EN_BIT]
                                 && (rx_sync[c] != rx_prev[c]);
         end
      end
   end

   // gpio pads: forced level/driver in suspend, else the normal function
   always_ff @(posedge i_clock or negedge i_rstn) begin
      if (!i_rstn) begin
         o_gpio_out <= '0;
         o_gpio_oe  <= '0;
      end else begin
         for (int c = 0; c < CHANNELS; c++) begin
            if (forced[c]) begin
               for (int p = 0; p < IO_COUNT; p++) begin
                  if (drv_map[c][p]) begin
                     // open-drain: drive low for a 0 level, release for a 1
                     o_gpio_out[c][p] <= 1'b0;
                     o_gpio_oe[c][p]  <= !lvl_map[c][p];
                  end else begin
                     o_gpio_out[c][p] <= lvl_map[c][p];
                     o_gpio_oe[c][p]  <= 1'b1;
                  end
               end
            end else begin
               o_gpio_out[c] <= i_gpio_out[c];
               o_gpio_oe[c]  <= i_gpio_oe[c];
            end
         end
      end
   end

   // ---- checks ----
   default clocking chk_clk @(posedge i_clock); endclocking
   default disable iff (!i_rstn);

   // completing write to a given byte
   sequence wr_done(logic [9:0] idx);
      acc_done && i_pwrite && (i_paddr == ADDR_WIDTH'({idx, 2'b00}));
   endsequence

   sequence access_open;
      i_psel && i_penable && !o_pready;
   endsequence

   // an access phase that opens on an address the bank refuses
   sequence refused_req;
      access_open and !dec[4];
   endsequence

   apb_one_wait_a: assert property (access_open |=> o_pready ##1 !o_pready)
      else $error("pready not one cycle after access start");
   unmapped_error_a: assert property (refused_req |=> o_pslverr && o_pready)
      else $error("unmapped access did not error");
   pullup_follow_a: assert property (wr_done(CH0_DATA_PIN_CONFIG_IDX) ##1 !acc_done[*1]
      |=> o_rx_pullup_en[0] == !$past(i_pwdata[7], 2))
      else $error("rx pull-up does not follow written bit");
   pulldown_excl_a: assert property ((o_rx_pullup_en & o_rx_pulldown_en) == '0)
      else $error("pull-down on while pull-up on");
   wake_gate_a: assert property (o_wake_request[0] |-> $past(i_global_wake_en)
      && $past(cfg[0][SLOT_DATA_PIN][RX_WAKE_EN_BIT]) && $past(susp_sync))
      else $error("wake without both enables");
   tx_driver_a: assert property ($past(cfg[0][SLOT_DATA_PIN][TX_OPEN_DRAIN_BIT])
      |-> !o_tx_out[0] && (o_tx_oe[0] == !$past(i_tx_data[0])))
      else $error("tx open-drain drive wrong");
   tx_ch1_a: assert property (wr_done(CH1_DATA_PIN_CONFIG_IDX) ##1 !acc_done
      |=> o_tx_oe[1] == ($past(i_pwdata[0], 2) ? !$past(i_tx_data[1]) : 1'b1))
      else $error("channel 1 tx driver not from its own byte");
   suspend_gate_a: assert property ($past(i_rstn) && !$past(forced[0])
      |-> o_gpio_oe[0] == $past(i_gpio_oe[0]) && o_gpio_out[0] == $past(i_gpio_out[0]))
      else $error("gpio overridden without master bit");
   forced_io9_a: assert property ($past(forced[0]) && !$past(cfg[0][SLOT_DRIVER_HIGH][HI_IO9_BIT])
      |-> o_gpio_oe[0][9] && o_gpio_out[0][9] == $past(cfg[0][SLOT_LEVEL_HIGH][HI_IO9_BIT]))
      else $error("io9 suspend push-pull level wrong");
   forced_io1_od_a: assert property ($past(forced[0]) && $past(cfg[0][SLOT_DRIVER_LOW][LO_IO1_BIT])
      |-> !o_gpio_out[0][1] && o_gpio_oe[0][1] == !$past(cfg[0][SLOT_LEVEL_LOW][LO_IO1_BIT]))
      else $error("io1 suspend open-drain wrong");
   master_bit_a: assert property (susp_sync && !cfg[0][SLOT_DRIVER_LOW][USE_SUSPEND_BIT] |-> !forced[0])
      else $error("override active with master bit clear");

   // the checks below cover the second channel, the idle bus, the
   // data-pin outputs and the channel 0 suspend pads; the first edge after reset is skipped where a
   // registered output still shows its reset value there

   // a refused transfer must not change the channel 0 data-pin byte at its completing edge
   refused_keep_a: assert property (refused_req |=> ##1 $stable(cfg[0][SLOT_DATA_PIN]))
      else $error("refused access changed a register");

   // read data is zero whenever no answer stands
   rdata_idle_a: assert property (!o_pready |-> o_prdata == 32'h0000_0000)
      else $error("read data outside an answer");

   // pready only answers an access phase
   pready_idle_a: assert property (!i_psel |=> !o_pready)
      else $error("pready without a request");

   // reserved data-pin bits never hold a one
   reserved_zero_a: assert property (cfg[0][SLOT_DATA_PIN][4:1] == 4'h0
      && cfg[1][SLOT_DATA_PIN][4:1] == 4'h0)
      else $error("reserved data-pin bit set");

   // channel 1 pull-up follows its own byte
   pullup_ch1_a: assert property ($past(i_rstn)
      |-> o_rx_pullup_en[1] == !$past(cfg[1][SLOT_DATA_PIN][RX_PULLUP_OFF_BIT]))
      else $error("channel 1 pull-up wrong");

   // channel 1 pull-down comes on when asked and the pull-up is off
   pulldown_ch1_a: assert property ($past(cfg[1][SLOT_DATA_PIN][RX_PULLDOWN_EN_BIT])
      && $past(cfg[1][SLOT_DATA_PIN][RX_PULLUP_OFF_BIT]) |-> o_rx_pulldown_en[1])
      else $error("channel 1 pull-down missing");

   // settled rx level moved while channel 0 wake was armed
   sequence rx0_edge_armed;
      susp_sync && i_global_wake_en && cfg[0][SLOT_DATA_PIN][RX_WAKE_EN_BIT]
         && (rx_sync[0] != rx_prev[0]);
   endsequence

   wake_edge_a: assert property (rx0_edge_armed |=> o_wake_request[0])
      else $error("armed rx edge gave no wake");

   // channel 1 wakes only with both enables
   wake_ch1_gate_a: assert property (o_wake_request[1] |-> $past(i_global_wake_en)
      && $past(cfg[1][SLOT_DATA_PIN][RX_WAKE_EN_BIT]))
      else $error("channel 1 wake without enables");

   // push-pull tx copies the uart data and always drives
   tx_push_pull_a: assert property ($past(i_rstn)
      && !$past(cfg[0][SLOT_DATA_PIN][TX_OPEN_DRAIN_BIT])
      |-> o_tx_oe[0] && o_tx_out[0] == $past(i_tx_data[0]))
      else $error("tx push-pull drive wrong");

   // an active override leaves the rx pull-up to its own byte
   rx_keep_susp_a: assert property ($past(forced[0])
      |-> o_rx_pullup_en[0] == !$past(cfg[0][SLOT_DATA_PIN][RX_PULLUP_OFF_BIT]))
      else $error("suspend touched the rx pull-up");

   // channel 1 keeps its normal pad drive without its master bit
   gate_ch1_a: assert property ($past(i_rstn) && !$past(forced[1])
      |-> o_gpio_oe[1] == $past(i_gpio_oe[1]) && o_gpio_out[1] == $past(i_gpio_out[1]))
      else $error("channel 1 gpio overridden without master bit");

   // low level byte drives io2 in push-pull
   forced_io2_a: assert property ($past(forced[0]) && !$past(cfg[0][SLOT_DRIVER_LOW][LO_IO2_BIT])
      |-> o_gpio_oe[0][2] && o_gpio_out[0][2] == $past(cfg[0][SLOT_LEVEL_LOW][LO_IO2_BIT]))
      else $error("io2 suspend push-pull level wrong");

   // high driver byte makes io5 open-drain
   forced_io5_od_a: assert property ($past(forced[0]) && $past(cfg[0][SLOT_DRIVER_HIGH][HI_IO5_BIT])
      |-> !o_gpio_out[0][5] && o_gpio_oe[0][5] == !$past(cfg[0][SLOT_LEVEL_HIGH][HI_IO5_BIT]))
      else $error("io5 suspend open-drain wrong");

endmodule : uart_pin_suspend_config

// [rtl/pin_suspend_pkg.sv]
// constants for the per-channel data-pin and suspend pin configuration block
package pin_suspend_pkg;

   // printed offsets are register indices; byte address is four times the index
   localparam logic [9:0] CH0_DATA_PIN_CONFIG_IDX     = 10'h02e;
   localparam logic [9:0] CH0_SUSPEND_LEVEL_HIGH_IDX  = 10'h02f;
   localparam logic [9:0] CH0_SUSPEND_LEVEL_LOW_IDX   = 10'h030;
   localparam logic [9:0] CH0_SUSPEND_DRIVER_HIGH_IDX = 10'h031;
   localparam logic [9:0] CH0_SUSPEND_DRIVER_LOW_IDX  = 10'h032;
   localparam logic [9:0] CH1_DATA_PIN_CONFIG_IDX     = 10'h041;
   localparam logic [9:0] CH1_SUSPEND_LEVEL_HIGH_IDX  = 10'h042;
   localparam logic [9:0] CH1_SUSPEND_LEVEL_LOW_IDX   = 10'h043;
   localparam logic [9:0] CH1_SUSPEND_DRIVER_HIGH_IDX = 10'h044;
   localparam logic [9:0] CH1_SUSPEND_DRIVER_LOW_IDX  = 10'h045;

   // slot of each byte inside one channel's bank
   localparam logic [2:0] SLOT_DATA_PIN     = 3'h0;
   localparam logic [2:0] SLOT_LEVEL_HIGH   = 3'h1;
   localparam logic [2:0] SLOT_LEVEL_LOW    = 3'h2;
   localparam logic [2:0] SLOT_DRIVER_HIGH  = 3'h3;
   localparam logic [2:0] SLOT_DRIVER_LOW   = 3'h4;
   localparam int         SLOT_COUNT        = 5;

   // data-pin byte fields
   localparam int RX_PULLUP_OFF_BIT   = 7;
   localparam int RX_PULLDOWN_EN_BIT  = 6;
   localparam int RX_WAKE_EN_BIT      = 5;
   localparam int TX_OPEN_DRAIN_BIT   = 0;
   // master suspend-control bit sits in the low driver byte
   localparam int USE_SUSPEND_BIT     = 7;

   // high byte bit positions (level and driver share them)
   localparam int HI_IO9_BIT = 7;
   localparam int HI_IO8_BIT = 6;
   localparam int HI_IO7_BIT = 3;
   localparam int HI_IO4_BIT = 2;
   localparam int HI_IO5_BIT = 1;
   localparam int HI_IO6_BIT = 0;
   // low byte bit positions
   localparam int LO_IO2_BIT = 5;
   localparam int LO_IO3_BIT = 4;
   localparam int LO_IO0_BIT = 3;
   localparam int LO_IO1_BIT = 2;

   // writable bits of each byte; reserved and unused bits read zero
   localparam logic [7:0] MASK_DATA_PIN    = 8'he1;
   localparam logic [7:0] MASK_HIGH        = 8'hcf;
   localparam logic [7:0] MASK_LEVEL_LOW   = 8'h3c;
   localparam logic [7:0] MASK_DRIVER_LOW  = 8'hbc;

   // every byte resets to zero
   localparam logic [7:0] CONFIG_RESET     = 8'h00;

endpackage : pin_suspend_pkg

// [verification/test_uart_pin_suspend_config.sv]
// self-checking bench for the data-pin and suspend pin configuration block
`timescale 1ns/1ps
module test_uart_pin_suspend_config;
   import pin_suspend_pkg::*;
   logic             i_clock, i_rstn;              // clock and async reset
   logic             i_psel, i_penable, i_pwrite;  // apb request
   logic [11:0]      i_paddr;                      // byte address
   logic [31:0]      i_pwdata, o_prdata;           // apb data
   logic             o_pready, o_pslverr;          // apb answer
   logic             i_usb_suspend;                // usb suspend level
   logic             i_global_wake_en;             // global wakeup enable
   logic [1:0]       i_rx_pin, i_tx_data;          // data pin inputs
   logic [1:0]       o_tx_out, o_tx_oe;            // tx pad drive
   logic [1:0]       o_rx_pullup_en, o_rx_pulldown_en, o_wake_request;
   logic [1:0][9:0]  i_gpio_out, i_gpio_oe, o_gpio_out, o_gpio_oe;
   int               fails, n_tests;               // mismatch and compare counters
   logic [7:0]       rd;                           // read data
   logic             er;                           // slave error
   int               k, cnt0, cnt1;
   // bit of each io inside its suspend byte; io0..io3 live in the low bytes
   int map_pos [10] = '{LO_IO0_BIT, LO_IO1_BIT, LO_IO2_BIT, LO_IO3_BIT, HI_IO4_BIT,
                        HI_IO5_BIT, HI_IO6_BIT, HI_IO7_BIT, HI_IO8_BIT, HI_IO9_BIT};
   logic [7:0] msk [5] = '{MASK_DATA_PIN, MASK_HIGH, MASK_LEVEL_LOW, MASK_HIGH, MASK_DRIVER_LOW};

   uart_pin_suspend_config u_dut (.i_clock(i_clock), .i_rstn(i_rstn), .i_psel(i_psel), .i_penable(i_penable),
      .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready),
      .o_pslverr(o_pslverr), .i_usb_suspend(i_usb_suspend), .i_global_wake_en(i_global_wake_en),
      .i_rx_pin(i_rx_pin), .i_tx_data(i_tx_data), .o_tx_out(o_tx_out), .o_tx_oe(o_tx_oe),
      .o_rx_pullup_en(o_rx_pullup_en), .o_rx_pulldown_en(o_rx_pulldown_en), .o_wake_request(o_wake_request),
      .i_gpio_out(i_gpio_out), .i_gpio_oe(i_gpio_oe), .o_gpio_out(o_gpio_out), .o_gpio_oe(o_gpio_oe));

   // 250 MHz clock
   initial begin
      i_clock = 1'b0;
      forever #2 i_clock = ~i_clock;
   end

   task automatic results();
      $display("checks %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : results

   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         fails++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check

   // one apb transfer; the request is held until pready is sampled high
   task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
      @(posedge i_clock);
      i_psel    <= 1'b1;
      i_penable <= 1'b0;
      i_pwrite  <= w;
      i_paddr   <= a;
      i_pwdata  <= {24'h0, d};
      @(posedge i_clock);
      i_penable <= 1'b1;
      do @(posedge i_clock); while (o_pready !== 1'b1);
      rd = o_prdata[7:0];
      er = o_pslverr;
      i_psel    <= 1'b0;
      i_penable <= 1'b0;
   endtask : apb

   function automatic logic [9:0] ra(input int c, input int s);
      return (c == 1 ? CH1_DATA_PIN_CONFIG_IDX : CH0_DATA_PIN_CONFIG_IDX) + 10'(s);
   endfunction : ra

   task automatic wr(input int c, input int s, input logic [7:0] d);
      apb(1'b1, {ra(c, s), 2'b00}, d);
   endtask : wr

   task automatic rdc(input int c, input int s, input logic [7:0] exp);
      apb(1'b0, {ra(c, s), 2'b00}, 8'h00);
      check("read_data", rd, exp);
   endtask : rdc

   task automatic sus(input int c, input logic [7:0] lh, ll, dh, dl);
      wr(c, SLOT_LEVEL_HIGH, lh);
      wr(c, SLOT_LEVEL_LOW, ll);
      wr(c, SLOT_DRIVER_HIGH, dh);
      wr(c, SLOT_DRIVER_LOW, dl);
   endtask : sus

   // expected pad drive worked out from the suspend bytes or the normal inputs
   task automatic pads(input int c, input logic s, input logic [7:0] lh, ll, dh, dl);
      logic [9:0] eo, ee;
      logic       l, d;
      for (int i = 0; i < 10; i++) begin
         l = (i < 4) ? ll[map_pos[i]] : lh[map_pos[i]];
         d = (i < 4) ? dl[map_pos[i]] : dh[map_pos[i]];
         if (s && dl[USE_SUSPEND_BIT]) begin
            eo[i] = d ? 1'b0 : l;
            ee[i] = d ? ~l : 1'b1;
         end else begin
            eo[i] = i_gpio_out[c][i];
            ee[i] = i_gpio_oe[c][i];
         end
      end
      check("gpio_out", o_gpio_out[c], eo);
      check("gpio_oe", o_gpio_oe[c], ee);
   endtask : pads

   task automatic wake_count(input logic [1:0] rx);
      i_rx_pin <= rx;
      cnt0 = 0;
      cnt1 = 0;
      repeat (8) begin
         @(posedge i_clock);
         if (o_wake_request[0] === 1'b1) cnt0++;
         if (o_wake_request[1] === 1'b1) cnt1++;
      end
   endtask : wake_count

   // watchdog: the whole run needs a few hundred cycles
   initial begin
      repeat (20000) @(posedge i_clock);
      fails++;
      results();
   end

   initial begin
      i_rstn = 1'b0; i_psel = 1'b0; i_penable = 1'b0; i_pwrite = 1'b0; i_paddr = 12'h000;
      i_pwdata = 32'h0; i_usb_suspend = 1'b0; i_global_wake_en = 1'b0; i_rx_pin = 2'b11;
      i_tx_data = 2'b00; i_gpio_out = {10'h15a, 10'h2a5}; i_gpio_oe = {10'h3c3, 10'h0f0};
      fails = 0; n_tests = 0;
      repeat (12) @(posedge i_clock);
      i_rstn <= 1'b1;
      repeat (3) @(posedge i_clock);
      check("pullup", o_rx_pullup_en, 2'b11);
      check("tx_oe", o_tx_oe, 2'b11);
      for (k = 0; k < 10; k++) rdc(k / 5, k % 5, CONFIG_RESET);
      for (k = 0; k < 10; k++) wr(k / 5, k % 5, (k % 5 == 0) ? MASK_DATA_PIN : 8'hff);
      for (k = 0; k < 10; k++) rdc(k / 5, k % 5, msk[k % 5]);
      apb(1'b0, 12'h000, 8'h00);
      check("unmapped_err", {er, rd}, 9'h100);
      // pull-down asked while pull-up stays on; channel 1 pull-up off, tx open-drain
      wr(0, SLOT_DATA_PIN, 8'h40);
      wr(1, SLOT_DATA_PIN, 8'hc1);
      apb(1'b1, {ra(0, SLOT_DATA_PIN), 2'b10}, 8'hff);
      check("misaligned_err", er, 1'b1);
      rdc(0, SLOT_DATA_PIN, 8'h40);
      i_tx_data <= 2'b11;
      repeat (3) @(posedge i_clock);
      check("pullup", o_rx_pullup_en, 2'b01);
      check("pulldown", o_rx_pulldown_en, 2'b10);
      check("tx_out", o_tx_out, 2'b01);
      check("tx_oe", o_tx_oe, 2'b01);
      i_tx_data <= 2'b00;
      repeat (3) @(posedge i_clock);
      check("tx_out", o_tx_out, 2'b00);
      check("tx_oe", o_tx_oe, 2'b11);
      // channel 0 forced push-pull, channel 1 master bit clear
      sus(0, 8'hc5, 8'h28, 8'h00, 8'h80);
      sus(1, 8'h0a, 8'h14, 8'hcf, 8'h3c);
      i_usb_suspend <= 1'b1;
      repeat (6) @(posedge i_clock);
      pads(0, 1'b1, 8'hc5, 8'h28, 8'h00, 8'h80);
      pads(1, 1'b1, 8'h0a, 8'h14, 8'hcf, 8'h3c);
      check("pullup", o_rx_pullup_en, 2'b01);
      check("tx_oe", o_tx_oe, 2'b11);
      // open-drain on both channels: high levels release the pad
      wr(0, SLOT_DRIVER_HIGH, 8'h0a);
      wr(1, SLOT_DRIVER_LOW, 8'hbc);
      repeat (3) @(posedge i_clock);
      pads(0, 1'b1, 8'hc5, 8'h28, 8'h0a, 8'h80);
      pads(1, 1'b1, 8'h0a, 8'h14, 8'hcf, 8'hbc);
      i_usb_suspend <= 1'b0;
      i_gpio_out <= {10'h0f3, 10'h30c};
      repeat (6) @(posedge i_clock);
      pads(0, 1'b0, 8'hc5, 8'h28, 8'h0a, 8'h80);
      pads(1, 1'b0, 8'h0a, 8'h14, 8'hcf, 8'hbc);
      // rx wakeup needs its own enable and the global one
      wr(0, SLOT_DATA_PIN, 8'h20);
      i_usb_suspend <= 1'b1;
      repeat (6) @(posedge i_clock);
      wake_count(2'b00);
      check("wake_no_global", cnt0, 0);
      i_global_wake_en <= 1'b1;
      repeat (2) @(posedge i_clock);
      wake_count(2'b11);
      check("wake_ch0", cnt0, 1);
      check("wake_ch1", cnt1, 0);
      results();
   end
endmodule : test_uart_pin_suspend_config
